// [psm_pkg.sv]
// shared constants for the power save mode controller
package psm_pkg;

    // ==========================================================
    // register map (byte addresses on the apb bus)
    // ==========================================================
    localparam int PSM_ADDR_W = 12;
    localparam logic [11:0] PSM_OFS_CLOCK_DIVISOR = 12'h000;
    localparam logic [11:0] PSM_OFS_MODULE_GATE = 12'h004;
    localparam logic [11:0] PSM_OFS_STATUS = 12'h008;

    // ==========================================================
    // clock_divisor_register fields
    // ==========================================================
    localparam int PSM_RESTORE_BIT = 15;
    localparam int PSM_RATIO_HI = 14;
    localparam int PSM_RATIO_LO = 12;
    localparam int PSM_DOZE_EN_BIT = 11;
    localparam logic [2:0] PSM_RATIO_RESET = 3'h0;
    localparam logic PSM_DOZE_EN_RESET = 1'b0;
    localparam logic PSM_RESTORE_RESET = 1'b0;

    // ==========================================================
    // module_clock_gate register and peripheral set
    // ==========================================================
    localparam int PSM_NUM_MODULES = 8;
    localparam logic [7:0] PSM_GATE_RESET = 8'h00;
    localparam logic [7:0] PSM_MOD_PRESENT = 8'h7F;
    localparam logic [7:0] PSM_MOD_EXT_CLOCK = 8'h03;

    // ==========================================================
    // status register fields and doze counter
    // ==========================================================
    localparam int PSM_STAT_MODE_LO = 0;
    localparam int PSM_STAT_DOZE_BIT = 2;
    localparam int PSM_STAT_OSC_LO = 4;
    localparam int PSM_DOZE_CNT_W = 7;

    // ==========================================================
    // controller states
    // ==========================================================
    typedef enum logic [2:0] {
        PSM_ST_RUN = 3'b000,
        PSM_ST_ENTER_IDLE = 3'b001,
        PSM_ST_IDLE = 3'b010,
        PSM_ST_ENTER_SLEEP = 3'b011,
        PSM_ST_SLEEP = 3'b100
    } psm_state_type;

endpackage : psm_pkg

// [psm_power_save_ctrl.sv]
// power save mode controller: sleep, idle, doze and per-module clock gating
//
// Added by the designer: the register addresses and the APB slave port.
`timescale 1ns/100ps
`default_nettype none

// Behaviour
// R1: sleep or idle only via power save instruction
// R2: sleep stops clocks and all execution
// R3: idle halts cpu, peripherals keep running
// R4: wake on enabled interrupt, timeout or reset
// R5: sleep shuts down system oscillator
// R6: clock failure monitor inactive in sleep
// R7: low power rc runs in sleep if watchdog
// R8: watchdog cleared just before sleep entry
// R9: sleep disables system clocked peripherals only
// R10: resume with oscillator active at sleep entry
// R11: idle entry stops cpu, clears watchdog
// R12: idle keeps oscillator, gated modules stay off
// R13: idle rc clock runs for watchdog or monitor
// R14: idle wake reapplies cpu clock at once; with doze on and ratio code above 0 the first cpu enable comes later
// R15: interrupt during entry deferred, then wakes
// R16: doze slows only the cpu clock
// R17: bit 11 enables doze
// R18: bits 14:12 ratio, 1:1 to 1:128
// R19: bit 15 lets interrupts restore speed
// R20: gated module loses clocks and registers
// R21: module runs only if present and ungated
// R22: gate changes act one cycle later
// R23: ratio code n divides by two to n
module psm_power_save_ctrl
    import psm_pkg::*;
(
    input wire logic CLOCK, // system clock, 50 mhz
    input wire logic RST, // synchronous reset, active high
    input wire logic PSEL, // apb select
    input wire logic PENABLE, // apb access phase
    input wire logic PWRITE, // apb write when high
    input wire logic [11:0] PADDR, // apb byte address
    input wire logic [31:0] PWDATA, // apb write data
    output logic [31:0] PRDATA, // apb read data
    output logic PREADY, // apb ready
    output logic PSLVERR, // apb error on unmapped address
    input wire logic PWRSAVE_EXEC, // power save instruction executes (pulse)
    input wire logic PWRSAVE_SLEEP, // instruction operand: 1 sleep, 0 idle
    input wire logic IRQ_PENDING, // an individually enabled interrupt is pending
    input wire logic WDT_TIMEOUT, // watchdog time-out pulse
    input wire logic WDT_ENABLE, // watchdog enabled level
    input wire logic CLOCK_FAILURE_MONITOR_ENABLE, // clock failure monitor enabled level
    input wire logic [2:0] NEXT_OSC_SELECT, // oscillator source now in use
    output logic CPU_CLK_EN, // cpu clock enable pulse
    output logic SYSOSC_ENABLE, // system oscillator may run
    output logic CLOCK_FAILURE_MONITOR_ACTIVE, // clock failure monitor active
    output logic LOW_POWER_RC_CLOCK_RUN, // low power rc clock must run
    output logic WDT_CLEAR, // clear watchdog counter (pulse)
    output logic WAKE, // wake up event (pulse)
    output logic WAKE_TO_ISR, // wake was caused by an interrupt
    output logic [2:0] RESUME_OSC_SEL, // oscillator to restart after sleep
    output logic [7:0] MODULE_CLK_EN, // per module clock enable
    output logic [7:0] MODULE_REG_EN // per module register access enable
);

    // ==========================================================
    // helper functions
    // ==========================================================
    // divisor minus one for a ratio code, shared by the doze counter and the cpu enable
    function automatic logic [6:0] doze_last(input logic [2:0] ratio);
        logic [7:0] div;
        div = 8'h01 << ratio; // R23
        return 7'(div - 8'h01);
    endfunction : doze_last

    // ==========================================================
    // declarations
    // ==========================================================
    psm_state_type state_reg; // controller mode
    psm_state_type state_next; // next controller mode
    logic doze_en_reg; // reduced_cpu_clock_enable
    logic [2:0] ratio_reg; // doze ratio code
    logic restore_reg; // restore_speed_on_interrupt
    logic [7:0] gate_reg; // module_clock_gate bits, 1 = off
    logic [6:0] doze_cnt_reg; // cpu divider phase
    logic [2:0] osc_reg; // oscillator captured at sleep entry
    logic wake_now; // a wake source is present
    logic setup_phase; // apb setup cycle
    logic wr_access; // apb write takes effect this edge
    logic [31:0] rd_mux; // read data for the current address
    logic addr_ok; // address maps to a register
    logic [7:0] gate_wdata; // gate bits from the bus
    logic cpu_en_next; // next cpu enable pulse
    logic in_sleep_next; // next state is sleep or its entry
    logic halted_next; // next state has the cpu stopped

    // ==========================================================
    // apb slave: one setup cycle, ready in the first access cycle
    // ==========================================================
    assign setup_phase = PSEL && !PENABLE;
    assign wr_access = PSEL && PENABLE && PREADY && PWRITE;
    assign gate_wdata = PWDATA[7:0];

    // read decode, reserved bits read as zero
    always_comb begin
        rd_mux = 32'h0000_0000;
        addr_ok = 1'b1;
        case (PADDR)
            PSM_OFS_CLOCK_DIVISOR: begin
                rd_mux[PSM_RESTORE_BIT] = restore_reg;
                rd_mux[PSM_RATIO_HI:PSM_RATIO_LO] = ratio_reg;
                rd_mux[PSM_DOZE_EN_BIT] = doze_en_reg;
            end
            PSM_OFS_MODULE_GATE: begin
                rd_mux[7:0] = gate_reg;
            end
            PSM_OFS_STATUS: begin
                rd_mux[PSM_STAT_MODE_LO +: 3] = state_reg;
                rd_mux[PSM_STAT_DOZE_BIT] = doze_en_reg;
                rd_mux[PSM_STAT_OSC_LO +: 3] = osc_reg;
            end
            default: begin
                addr_ok = 1'b0; // unmapped: zero data and an error
            end
        endcase
    end

    // answer registers, loaded in the setup cycle
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            PREADY <= 1'b0;
            PRDATA <= 32'h0000_0000;
            PSLVERR <= 1'b0;
        end else begin
            PREADY <= setup_phase;
            PRDATA <= (setup_phase && !PWRITE) ? rd_mux : 32'h0000_0000;
            PSLVERR <= setup_phase && !addr_ok;
        end
    end

    // ==========================================================
    // clock divisor register, with restore on interrupt
    // ==========================================================
    // the hardware clear wins over a same-cycle write, so a pending
    // interrupt cannot be stranded at the slow rate by software
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            doze_en_reg <= PSM_DOZE_EN_RESET;
            ratio_reg <= PSM_RATIO_RESET; // R18
            restore_reg <= PSM_RESTORE_RESET;
        end else begin
            if (wr_access && PADDR == PSM_OFS_CLOCK_DIVISOR) begin
                doze_en_reg <= PWDATA[PSM_DOZE_EN_BIT]; // R17
                ratio_reg <= PWDATA[PSM_RATIO_HI:PSM_RATIO_LO]; // R18
                restore_reg <= PWDATA[PSM_RESTORE_BIT];
            end
            if (restore_reg && IRQ_PENDING) begin
                doze_en_reg <= 1'b0; // R19
            end
        end
    end

    // module gate register, reset to all enabled
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            gate_reg <= PSM_GATE_RESET; // R21
        end else if (wr_access && PADDR == PSM_OFS_MODULE_GATE) begin
            gate_reg <= gate_wdata;
        end
    end

    // ==========================================================
    // mode state machine
    // ==========================================================
    assign wake_now = IRQ_PENDING || WDT_TIMEOUT; // R4

    // entry states hold off any wake so entry always completes
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            PSM_ST_RUN: begin
                if (PWRSAVE_EXEC) begin // R1
                    state_next = PWRSAVE_SLEEP ? PSM_ST_ENTER_SLEEP : PSM_ST_ENTER_IDLE;
                end
            end
            PSM_ST_ENTER_IDLE: begin
                state_next = PSM_ST_IDLE; // R15
            end
            PSM_ST_ENTER_SLEEP: begin
                state_next = PSM_ST_SLEEP; // R15
            end
            PSM_ST_IDLE, PSM_ST_SLEEP: begin
                if (wake_now) begin
                    state_next = PSM_ST_RUN; // R4
                end
            end
            default: begin
                state_next = PSM_ST_RUN;
            end
        endcase
    end

    // state register; a device reset always returns to run
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            state_reg <= PSM_ST_RUN; // R4
        end else begin
            state_reg <= state_next;
        end
    end

    // wake pulse and its cause for the cpu
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            WAKE <= 1'b0;
            WAKE_TO_ISR <= 1'b0;
        end else begin
            WAKE <= 1'b0;
            if ((state_reg == PSM_ST_IDLE || state_reg == PSM_ST_SLEEP) && wake_now) begin
                WAKE <= 1'b1; // R14
                WAKE_TO_ISR <= IRQ_PENDING; // R14
            end
        end
    end

    // oscillator capture at sleep entry, held through sleep
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            osc_reg <= 3'h0;
        end else if (state_reg == PSM_ST_RUN && state_next == PSM_ST_ENTER_SLEEP) begin
            osc_reg <= NEXT_OSC_SELECT; // R10
        end
    end
    assign RESUME_OSC_SEL = osc_reg; // R10

    // ==========================================================
    // doze divider for the cpu enable
    // ==========================================================
    // the divider restarts whenever doze is off, so the first slow
    // pulse comes a full period after doze is enabled
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            doze_cnt_reg <= 7'h00;
        end else if (!doze_en_reg || state_reg != PSM_ST_RUN) begin
            doze_cnt_reg <= 7'h00;
        end else if (doze_cnt_reg >= doze_last(ratio_reg)) begin
            doze_cnt_reg <= 7'h00;
        end else begin
            doze_cnt_reg <= 7'(doze_cnt_reg + 7'h01);
        end
    end

    assign halted_next = state_next != PSM_ST_RUN;
    assign in_sleep_next = state_next == PSM_ST_ENTER_SLEEP || state_next == PSM_ST_SLEEP;
    // only the cpu enable is divided; peripherals see every cycle
    assign cpu_en_next = !halted_next && (!doze_en_reg || doze_cnt_reg >= doze_last(ratio_reg)); // R16

    // ==========================================================
    // clock and power outputs
    // ==========================================================
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            CPU_CLK_EN <= 1'b1;
            SYSOSC_ENABLE <= 1'b1;
            CLOCK_FAILURE_MONITOR_ACTIVE <= 1'b0;
            LOW_POWER_RC_CLOCK_RUN <= 1'b0;
            WDT_CLEAR <= 1'b0;
        end else begin
            CPU_CLK_EN <= cpu_en_next; // R2 R3 R11 R14
            SYSOSC_ENABLE <= !in_sleep_next; // R5 R12
            CLOCK_FAILURE_MONITOR_ACTIVE <= CLOCK_FAILURE_MONITOR_ENABLE && !in_sleep_next; // R6
            // rc clock: watchdog only in sleep, either user otherwise
            LOW_POWER_RC_CLOCK_RUN <= in_sleep_next ? WDT_ENABLE : (WDT_ENABLE || CLOCK_FAILURE_MONITOR_ENABLE); // R7 R13
            WDT_CLEAR <= WDT_ENABLE && (state_next == PSM_ST_ENTER_SLEEP ||
                                        state_next == PSM_ST_ENTER_IDLE); // R8 R11
        end
    end

    // ==========================================================
    // module gating, one cycle behind the gate register
    // ==========================================================
    // modules on an external clock survive sleep; absent ones never run
    always_ff @(posedge CLOCK) begin
        if (RST) begin
            MODULE_CLK_EN <= PSM_MOD_PRESENT;
            MODULE_REG_EN <= PSM_MOD_PRESENT;
        end else begin
            MODULE_REG_EN <= ~gate_reg & PSM_MOD_PRESENT; // R20 R21 R22
            MODULE_CLK_EN <= ~gate_reg & PSM_MOD_PRESENT &
                             (in_sleep_next ? PSM_MOD_EXT_CLOCK : 8'hFF); // R9 R12 R20 R22
        end
    end

    // ==========================================================
    // assertions
    // ==========================================================
    default clocking cb @(posedge CLOCK); endclocking
    default disable iff (RST);

    run_leave_a: assert property ( // R1
        state_reg == PSM_ST_RUN && !PWRSAVE_EXEC |=> state_reg == PSM_ST_RUN)
        else $error("left run mode without a power save instruction");

    sleep_clocks_a: assert property ( // R2
        state_reg == PSM_ST_SLEEP |-> !CPU_CLK_EN && !SYSOSC_ENABLE && !CLOCK_FAILURE_MONITOR_ACTIVE)
        else $error("clocks still running in sleep");

    idle_clocks_a: assert property ( // R3
        state_reg == PSM_ST_IDLE |-> !CPU_CLK_EN && SYSOSC_ENABLE)
        else $error("idle clock enables wrong");

    wake_event_a: assert property ( // R4
        (state_reg == PSM_ST_SLEEP || state_reg == PSM_ST_IDLE) && wake_now
        |=> state_reg == PSM_ST_RUN && WAKE && CPU_CLK_EN == (!$past(doze_en_reg) || $past(ratio_reg) == 3'h0))
        else $error("no wake after an enabled wake source");

    entry_defer_a: assert property ( // R15
        state_reg == PSM_ST_ENTER_SLEEP || state_reg == PSM_ST_ENTER_IDLE
        |=> state_reg != PSM_ST_RUN && !WAKE)
        else $error("power save entry was cut short by a wake source");

    rc_clock_a: assert property ( // R7
        state_reg == PSM_ST_SLEEP && $past(WDT_ENABLE) |-> LOW_POWER_RC_CLOCK_RUN)
        else $error("rc clock stopped in sleep with watchdog on");

    wdt_entry_a: assert property ( // R8
        state_reg == PSM_ST_RUN && PWRSAVE_EXEC && WDT_ENABLE |=> WDT_CLEAR ##1 !WDT_CLEAR)
        else $error("watchdog not cleared once on entry");

    osc_hold_a: assert property ( // R10
        state_reg == PSM_ST_SLEEP |=> $stable(RESUME_OSC_SEL))
        else $error("resume oscillator changed during sleep");

    gate_delay_a: assert property ( // R22
        !$past(RST) |-> MODULE_REG_EN == (~$past(gate_reg) & PSM_MOD_PRESENT))
        else $error("module register enable not one cycle behind gate");

    doze_ratio_a: assert property ( // R18
        state_reg == PSM_ST_RUN && doze_en_reg && ratio_reg == 3'h1 && $stable(ratio_reg)
        && CPU_CLK_EN && state_next == PSM_ST_RUN |=> !CPU_CLK_EN)
        else $error("doze 1:2 gave two pulses in a row");

    restore_irq_a: assert property ( // R19
        restore_reg && IRQ_PENDING && doze_en_reg |=> !doze_en_reg)
        else $error("interrupt did not restore full speed");

    sleep_enter_c: cover property (state_reg == PSM_ST_RUN ##1 state_reg == PSM_ST_ENTER_SLEEP ##1
                                   state_reg == PSM_ST_SLEEP ##[1:20] WAKE);
    idle_wake_c: cover property (state_reg == PSM_ST_IDLE && IRQ_PENDING);
    doze_slow_c: cover property (doze_en_reg && ratio_reg == 3'h7 && CPU_CLK_EN);
    gate_off_c: cover property (gate_reg != 8'h00 ##1 MODULE_CLK_EN != PSM_MOD_PRESENT);

endmodule : psm_power_save_ctrl

`default_nettype wire

// [psm_cpu_model.sv]
// cpu core model on the far side of the power save controller
`timescale 1ns/100ps
`default_nettype none
module psm_cpu_model (
    input wire logic clk, // system clock
    input wire logic cpu_clk_en, // cpu clock enable from the controller
    output logic exec, // power save instruction executes (pulse)
    output logic sleep_sel, // instruction operand: 1 sleep, 0 idle
    output logic irq, // enabled interrupt pending (level)
    output logic wdt_to // watchdog time-out pulse
);
    int instr_count; // instructions retired, only while the cpu clock runs

    // ==========================================
    // idle lines at time zero
    // ==========================================
    initial begin
        exec = 1'b0;
        sleep_sel = 1'b0;
        irq = 1'b0;
        wdt_to = 1'b0;
        instr_count = 0;
    end

    // ==========================================
    // retire one instruction per cpu clock enable
    // ==========================================
    always @(posedge clk) begin
        if (cpu_clk_en === 1'b1) begin
            instr_count <= instr_count + 1;
        end
    end

    // one instruction cycle of the power save instruction; an interrupt may coincide
    task power_save(input logic slp, input logic with_irq);
        @(posedge clk);
        exec <= 1'b1;
        sleep_sel <= slp;
        irq <= with_irq;
        @(posedge clk);
        exec <= 1'b0;
        // operand is only meaningful with exec, so it shows the inverse afterwards
        sleep_sel <= ~slp;
    endtask : power_save

    // interrupt request level, changed right after an edge
    task set_irq(input logic v);
        @(posedge clk);
        irq <= v;
    endtask : set_irq

    // single cycle watchdog time-out
    task timeout_pulse();
        @(posedge clk);
        wdt_to <= 1'b1;
        @(posedge clk);
        wdt_to <= 1'b0;
    endtask : timeout_pulse
endmodule : psm_cpu_model
`default_nettype wire

// [psm_power_save_ctrl_tb.sv]
// self-checking testbench for the power save mode controller
`timescale 1ns/100ps
`default_nettype none
module psm_power_save_ctrl_tb
    import psm_pkg::*;
;
    // ==========================================
    // stimulus and observed signals
    // ==========================================
    logic clock, rst; // 50 mhz clock, synchronous reset
    logic psel, penable, pwrite; // apb control
    logic [11:0] paddr; // apb address
    logic [31:0] pwdata, prdata; // apb data
    logic pready, pslverr; // apb answer
    logic exec, sleep_sel, irq, wdt_to; // driven by the cpu model
    logic wdt_en, clock_failure_monitor_en; // watchdog and monitor enables
    logic [2:0] osc_sel, resume_osc; // oscillator in use and captured copy
    logic cpu_clk_en, sysosc_en, clock_failure_monitor_act, low_power_rc_clock_run, wdt_clr, wake, wake_isr; // power outputs
    logic [7:0] mod_clk_en, mod_reg_en; // per module enables
    logic [32:0] exp_q[$]; // expected {pslverr, prdata} per transfer
    logic [31:0] seed; // lfsr state
    logic [7:0] g; // random gate pattern
    logic [2:0] osc0; // oscillator captured at sleep entry
    int err_count, samples_checked, gap;

    psm_power_save_ctrl u_dut (.CLOCK(clock), .RST(rst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
        .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
        .PWRSAVE_EXEC(exec), .PWRSAVE_SLEEP(sleep_sel), .IRQ_PENDING(irq), .WDT_TIMEOUT(wdt_to),
        .WDT_ENABLE(wdt_en), .CLOCK_FAILURE_MONITOR_ENABLE(clock_failure_monitor_en), .NEXT_OSC_SELECT(osc_sel), .CPU_CLK_EN(cpu_clk_en),
        .SYSOSC_ENABLE(sysosc_en), .CLOCK_FAILURE_MONITOR_ACTIVE(clock_failure_monitor_act), .LOW_POWER_RC_CLOCK_RUN(low_power_rc_clock_run), .WDT_CLEAR(wdt_clr),
        .WAKE(wake), .WAKE_TO_ISR(wake_isr), .RESUME_OSC_SEL(resume_osc), .MODULE_CLK_EN(mod_clk_en),
        .MODULE_REG_EN(mod_reg_en));
    psm_cpu_model u_cpu (.clk(clock), .cpu_clk_en(cpu_clk_en), .exec(exec), .sleep_sel(sleep_sel),
        .irq(irq), .wdt_to(wdt_to));

    // ==========================================
    // helpers
    // ==========================================
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task chk(input logic [32:0] seen, input logic [32:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // one apb transfer; the answer is compared by the monitor below
    task apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] exp);
        int n;
        n = 0;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        exp_q.push_back(exp);
        @(posedge clock);
        penable <= 1'b1;
        // pready is sampled at the rising edge that completes the transfer
        do begin
            @(posedge clock);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (pready !== 1'b1) err_count++;
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d; // released data no longer shows the old word
    endtask : apb

    // wait for the wake pulse; exp of zero means any count within the bound
    task wait_wake(input int exp);
        int n;
        n = 0;
        do begin
            @(negedge clock);
            n++;
        end while (wake !== 1'b1 && n < 8);
        if (exp != 0) chk(33'(n), 33'(exp));
    endtask : wait_wake

    // cycles from one cpu clock pulse to the next
    task measure_gap();
        int n;
        n = 0;
        @(negedge clock);
        while (cpu_clk_en !== 1'b1 && n < 300) begin
            @(negedge clock);
            n++;
        end
        gap = 0;
        do begin
            @(negedge clock);
            gap++;
        end while (cpu_clk_en !== 1'b1 && gap < 300);
    endtask : measure_gap

    task wrap_up();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : wrap_up

    // ==========================================
    // clock, monitor and watchdog
    // ==========================================
    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // takes the oldest note whenever a transfer completes
    always @(negedge clock) begin
        if (psel && penable && pready === 1'b1) begin
            if (exp_q.size() == 0) chk({pslverr, prdata}, 33'h1_ffff_ffff);
            else chk({pslverr, prdata}, exp_q.pop_front());
        end
    end

    // the whole sequence needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clock);
        err_count++;
        wrap_up();
    end

    // ==========================================
    // main sequence
    // ==========================================
    initial begin
        rst = 1'b1;
        {psel, penable, pwrite} = 3'b000;
        paddr = 12'h000;
        pwdata = 32'h0;
        {wdt_en, clock_failure_monitor_en} = 2'b00;
        osc_sel = 3'h0;
        seed = 32'he0f4;
        err_count = 0;
        samples_checked = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        chk({32'h0, cpu_clk_en}, 33'h1);
        chk({25'h0, mod_reg_en}, {25'h0, PSM_MOD_PRESENT});
        apb(1'b0, PSM_OFS_CLOCK_DIVISOR, 32'h0, 33'h0);
        apb(1'b0, PSM_OFS_MODULE_GATE, 32'h0, 33'h0);
        seed = lfsr(seed);
        apb(1'b1, 12'h010, seed, 33'h1_0000_0000);
        apb(1'b0, 12'h00C, 32'h0, 33'h1_0000_0000);
        $display("test reset and map done");
        // gating: new value reaches the modules one cycle after the write
        seed = lfsr(seed);
        g = seed[7:0];
        apb(1'b1, PSM_OFS_MODULE_GATE, {24'h0, g}, 33'h0);
        @(negedge clock);
        chk({25'h0, mod_reg_en}, {25'h0, PSM_MOD_PRESENT});
        @(negedge clock);
        chk({25'h0, mod_reg_en}, {25'h0, ~g & PSM_MOD_PRESENT});
        chk({25'h0, mod_clk_en}, {25'h0, ~g & PSM_MOD_PRESENT});
        apb(1'b0, PSM_OFS_MODULE_GATE, 32'h0, {25'h0, g});
        $display("test gating done");
        // idle with random watchdog and monitor enables
        seed = lfsr(seed);
        {wdt_en, clock_failure_monitor_en} <= seed[5:4];
        u_cpu.power_save(1'b0, 1'b0);
        @(negedge clock);
        chk({30'h0, cpu_clk_en, wdt_clr, sysosc_en}, {31'h0, wdt_en, 1'b1});
        chk({31'h0, low_power_rc_clock_run, clock_failure_monitor_act}, {31'h0, wdt_en | clock_failure_monitor_en, clock_failure_monitor_en});
        @(negedge clock);
        chk({25'h0, mod_clk_en}, {25'h0, ~g & PSM_MOD_PRESENT});
        gap = u_cpu.instr_count;
        u_cpu.set_irq(1'b1);
        wait_wake(2);
        chk(33'(u_cpu.instr_count - gap), 33'h0);
        chk({31'h0, wake_isr, cpu_clk_en}, 33'h3);
        u_cpu.set_irq(1'b0);
        $display("test idle done");
        // sleep with watchdog, woken by a time-out
        wdt_en <= 1'b1;
        seed = lfsr(seed);
        osc0 = seed[6:4];
        osc_sel <= osc0;
        u_cpu.power_save(1'b1, 1'b0);
        osc_sel <= ~osc0;
        @(negedge clock);
        chk({28'h0, cpu_clk_en, wdt_clr, sysosc_en, clock_failure_monitor_act, 1'b0}, 33'h8);
        chk({30'h0, resume_osc}, {30'h0, osc0});
        @(negedge clock);
        chk({30'h0, wdt_clr, low_power_rc_clock_run, clock_failure_monitor_act}, 33'h2);
        chk({25'h0, mod_clk_en}, {25'h0, ~g & PSM_MOD_PRESENT & PSM_MOD_EXT_CLOCK});
        u_cpu.timeout_pulse();
        wait_wake(1);
        chk({31'h0, wake_isr, sysosc_en}, 33'h1);
        chk({30'h0, resume_osc}, {30'h0, osc0});
        @(negedge clock);
        chk({25'h0, mod_clk_en}, {25'h0, ~g & PSM_MOD_PRESENT});
        apb(1'b0, PSM_OFS_STATUS, 32'h0, {26'h0, osc0, 4'h0});
        $display("test sleep done");
        // interrupt coinciding with the instruction is held off, then wakes
        u_cpu.power_save(1'b0, 1'b1);
        @(negedge clock);
        chk({31'h0, cpu_clk_en, wake}, 33'h0);
        wait_wake(2);
        chk({32'h0, wake_isr}, 33'h1);
        u_cpu.set_irq(1'b0);
        $display("test deferred interrupt done");
        // doze at every ratio code
        for (int n = 0; n < 8; n++) begin
            apb(1'b1, PSM_OFS_CLOCK_DIVISOR, {17'h0, 3'(n), 1'b1, 11'h0}, 33'h0);
            measure_gap();
            chk(33'(gap), 33'(1 << n));
        end
        apb(1'b1, PSM_OFS_CLOCK_DIVISOR, 32'h0000_3800, 33'h0);
        u_cpu.set_irq(1'b1);
        u_cpu.set_irq(1'b0);
        apb(1'b0, PSM_OFS_CLOCK_DIVISOR, 32'h0, 33'h0_0000_3800);
        apb(1'b1, PSM_OFS_CLOCK_DIVISOR, 32'h0000_b800, 33'h0);
        u_cpu.set_irq(1'b1);
        u_cpu.set_irq(1'b0);
        apb(1'b0, PSM_OFS_CLOCK_DIVISOR, 32'h0, 33'h0_0000_b000);
        measure_gap();
        chk(33'(gap), 33'h1);
        $display("test doze done");
        // a device reset during sleep wakes straight into run
        u_cpu.power_save(1'b1, 1'b0);
        @(posedge clock);
        rst <= 1'b1;
        @(posedge clock);
        rst <= 1'b0;
        @(negedge clock);
        chk({31'h0, sysosc_en, cpu_clk_en}, 33'h3);
        chk({25'h0, mod_reg_en}, {25'h0, PSM_MOD_PRESENT});
        $display("test reset in sleep done");
        wrap_up();
    end
endmodule : psm_power_save_ctrl_tb
`default_nettype wire
